// File: rtl/irq_flag_pkg.sv
// constants and carrier types for the interrupt flag register block
package irq_flag_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 8;
  localparam int NUM_REGS = 3;

  // register indexes; the byte address is four times each index
  localparam logic [7:0] IDX_RADIO = 8'h9b;
  localparam logic [7:0] IDX_TIMER = 8'hc0;
  localparam logic [7:0] IDX_WDOG = 8'he8;
  localparam logic [ADDR_W-1:0] ADDR_RADIO = {2'b00, IDX_RADIO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TIMER = {2'b00, IDX_TIMER, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_WDOG = {2'b00, IDX_WDOG, 2'b00};

  // array slot of each register
  localparam int SLOT_RADIO = 0;
  localparam int SLOT_TIMER = 1;
  localparam int SLOT_WDOG = 2;

  localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;

  // radio_irq_flags fields
  localparam int POS_RADIO_FLAG_HIGH = 1;
  localparam int POS_RADIO_FLAG_LOW = 0;

  // timer_port0_dma_irq_flags fields
  localparam int POS_SLEEP_TIMER_FLAG = 7;
  localparam int POS_FORCE_SOURCE = 6;
  localparam int POS_PORT_ZERO_PIN_FLAG = 5;
  localparam int POS_TIMER_FOUR_FLAG = 4;
  localparam int POS_TIMER_THREE_FLAG = 3;
  localparam int POS_TIMER_TWO_FLAG = 2;
  localparam int POS_TIMER_ONE_FLAG = 1;
  localparam int POS_TRANSFER_DONE_FLAG = 0;

  // watchdog_port_serial_tx_irq_flags fields
  localparam int POS_WATCHDOG_FLAG = 4;
  localparam int POS_PORT_ONE_PIN_FLAG = 3;
  localparam int POS_SERIAL_B_TX_FLAG = 2;
  localparam int POS_SERIAL_A_TX_FLAG = 1;
  localparam int POS_PORT_TWO_PIN_FLAG = 0;

  // one-cycle event pulses from the peripherals
  typedef struct packed {
    logic radio;
    logic sleep_timer;
    logic port_zero;
    logic timer_four;
    logic timer_three;
    logic timer_two;
    logic timer_one;
    logic transfer_done;
    logic watchdog;
    logic port_one;
    logic serial_b_tx;
    logic serial_a_tx;
    logic port_two;
  } irq_evt_s;

  // one-cycle pulses from the core when it vectors to a timer routine
  typedef struct packed {
    logic timer_four;
    logic timer_three;
    logic timer_two;
    logic timer_one;
  } vec_ack_s;

  // pending request levels toward the core
  typedef irq_evt_s irq_req_s;

endpackage

// File: rtl/irq_flag_regs.sv
// interrupt flag registers three to five with an apb slave port
// What this block does
// - radio event sets both radio flag bits
// - software setting radio bit requests service
// - timer four sets bit 4, vector clears
// - timer three sets bit 3, vector clears
// - timer two sets bit 2, vector clears
// - timer one sets bit 1, vector clears
// - bit 7 shows sleep timer pending
// - bit 5 shows port zero pending
// - bit 0 shows transfer done pending
// - register five bit 4 shows watchdog
// - register five bit 3 shows port one
// - register five bit 2 shows serial b
// - register five bit 1 shows serial a
// - register five bit 0 shows port two
// - flags read pending, writable, reset zero
// - flags set regardless of enables
// - pending flag drives request toward core
//
// The APB register port was decided locally.
`timescale 1ns/1ns
module irq_flag_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irq_flag_pkg::ADDR_W-1:0] paddr,
  input wire logic [irq_flag_pkg::DATA_W-1:0] pwdata,
  output logic [irq_flag_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire irq_flag_pkg::irq_evt_s evt,
  input wire irq_flag_pkg::vec_ack_s ack,
  output irq_flag_pkg::irq_req_s req
);

  localparam int FW = irq_flag_pkg::FLAG_W;
  localparam int NR = irq_flag_pkg::NUM_REGS;

  logic [FW-1:0] flag_r [NR];
  logic [FW-1:0] flag_nxt [NR];
  logic [FW-1:0] set_v [NR];
  logic [FW-1:0] clr_v [NR];
  logic [NR-1:0] hit;
  logic setup_ph;
  logic access_ph;
  logic pready_r;
  logic pslverr_r;
  logic [irq_flag_pkg::DATA_W-1:0] prdata_r;
  logic [irq_flag_pkg::DATA_W-1:0] rd_mux;
  irq_flag_pkg::irq_req_s req_r;
  irq_flag_pkg::irq_req_s req_nxt;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable & pready_r;

  // full-address decode, so misaligned addresses miss
  always_comb begin
    hit = '0;
    hit[irq_flag_pkg::SLOT_RADIO] = (paddr == irq_flag_pkg::ADDR_RADIO);
    hit[irq_flag_pkg::SLOT_TIMER] = (paddr == irq_flag_pkg::ADDR_TIMER);
    hit[irq_flag_pkg::SLOT_WDOG] = (paddr == irq_flag_pkg::ADDR_WDOG);
  end

  // hardware set terms; enables play no part here
  always_comb begin
    for (int i = 0; i < NR; i++) begin
      set_v[i] = '0;
      clr_v[i] = '0;
    end
    set_v[irq_flag_pkg::SLOT_RADIO][irq_flag_pkg::POS_RADIO_FLAG_HIGH] =
      evt.radio;
    set_v[irq_flag_pkg::SLOT_RADIO][irq_flag_pkg::POS_RADIO_FLAG_LOW] =
      evt.radio;
    set_v[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_SLEEP_TIMER_FLAG] =
      evt.sleep_timer;
    set_v[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_PORT_ZERO_PIN_FLAG] =
      evt.port_zero;
    set_v[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_FOUR_FLAG] =
      evt.timer_four;
    set_v[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_THREE_FLAG] =
      evt.timer_three;
    set_v[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_TWO_FLAG] =
      evt.timer_two;
    set_v[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_ONE_FLAG] =
      evt.timer_one;
    set_v[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TRANSFER_DONE_FLAG] =
      evt.transfer_done;
    set_v[irq_flag_pkg::SLOT_WDOG][irq_flag_pkg::POS_WATCHDOG_FLAG] =
      evt.watchdog;
    set_v[irq_flag_pkg::SLOT_WDOG][irq_flag_pkg::POS_PORT_ONE_PIN_FLAG] =
      evt.port_one;
    set_v[irq_flag_pkg::SLOT_WDOG][irq_flag_pkg::POS_SERIAL_B_TX_FLAG] =
      evt.serial_b_tx;
    set_v[irq_flag_pkg::SLOT_WDOG][irq_flag_pkg::POS_SERIAL_A_TX_FLAG] =
      evt.serial_a_tx;
    set_v[irq_flag_pkg::SLOT_WDOG][irq_flag_pkg::POS_PORT_TWO_PIN_FLAG] =
      evt.port_two;
    // only the timer flags clear when the core vectors
    clr_v[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_FOUR_FLAG] =
      ack.timer_four;
    clr_v[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_THREE_FLAG] =
      ack.timer_three;
    clr_v[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_TWO_FLAG] =
      ack.timer_two;
    clr_v[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_ONE_FLAG] =
      ack.timer_one;
  end

  // set is or-ed last so an event never loses to a write or vector clear
  generate
    for (genvar g = 0; g < NR; g++) begin : g_flag
      always_comb begin
        if (access_ph && pwrite && hit[g]) begin
          flag_nxt[g] = pwdata[FW-1:0] | set_v[g];
        end else begin
          flag_nxt[g] = (flag_r[g] & ~clr_v[g]) | set_v[g];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_r[g] <= irq_flag_pkg::FLAG_RESET;
        end else begin
          flag_r[g] <= flag_nxt[g];
        end
      end
    end
  endgenerate

  // requests follow the flags in the same cycle; unused bits stay out
  always_comb begin
    req_nxt.radio =
      flag_nxt[irq_flag_pkg::SLOT_RADIO][irq_flag_pkg::POS_RADIO_FLAG_HIGH] |
      flag_nxt[irq_flag_pkg::SLOT_RADIO][irq_flag_pkg::POS_RADIO_FLAG_LOW];
    req_nxt.sleep_timer =
      flag_nxt[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_SLEEP_TIMER_FLAG];
    // a stray one in the force bit pins the port zero source on
    req_nxt.port_zero =
      flag_nxt[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_PORT_ZERO_PIN_FLAG]
      | flag_nxt[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_FORCE_SOURCE];
    req_nxt.timer_four =
      flag_nxt[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_FOUR_FLAG];
    req_nxt.timer_three =
      flag_nxt[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_THREE_FLAG];
    req_nxt.timer_two =
      flag_nxt[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_TWO_FLAG];
    req_nxt.timer_one =
      flag_nxt[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TIMER_ONE_FLAG];
    req_nxt.transfer_done =
      flag_nxt[irq_flag_pkg::SLOT_TIMER][irq_flag_pkg::POS_TRANSFER_DONE_FLAG];
    req_nxt.watchdog =
      flag_nxt[irq_flag_pkg::SLOT_WDOG][irq_flag_pkg::POS_WATCHDOG_FLAG];
    req_nxt.port_one =
      flag_nxt[irq_flag_pkg::SLOT_WDOG][irq_flag_pkg::POS_PORT_ONE_PIN_FLAG];
    req_nxt.serial_b_tx =
      flag_nxt[irq_flag_pkg::SLOT_WDOG][irq_flag_pkg::POS_SERIAL_B_TX_FLAG];
    req_nxt.serial_a_tx =
      flag_nxt[irq_flag_pkg::SLOT_WDOG][irq_flag_pkg::POS_SERIAL_A_TX_FLAG];
    req_nxt.port_two =
      flag_nxt[irq_flag_pkg::SLOT_WDOG][irq_flag_pkg::POS_PORT_TWO_PIN_FLAG];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end

  // read data is sampled in the setup cycle so prdata can be a flop
  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < NR; i++) begin
      if (hit[i]) begin
        rd_mux = {{(irq_flag_pkg::DATA_W - FW){1'b0}}, flag_r[i]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup_ph) begin
      prdata_r <= pwrite ? '0 : rd_mux;
    end
  end

  // every access completes in its first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup_ph;
    end
  end

  // unmapped address answers with an error and changes nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= setup_ph & ~(|hit);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign req = req_r;

endmodule // irq_flag_regs

// File: verif/irq_flag_regs_properties.sv
// port-level assertions for the interrupt flag register block
`timescale 1ns/1ns
module irq_flag_regs_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irq_flag_pkg::ADDR_W-1:0] paddr,
  input wire logic [irq_flag_pkg::DATA_W-1:0] pwdata,
  input wire logic [irq_flag_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire irq_flag_pkg::irq_evt_s evt,
  input wire irq_flag_pkg::vec_ack_s ack,
  input wire irq_flag_pkg::irq_req_s req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  assign wr = psel && penable && pwrite;
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_radio_set: assert property (evt.radio |=> req.radio)
    else $error("radio event not pending");
  a_radio_write: assert property (wr && pready &&
    paddr == irq_flag_pkg::ADDR_RADIO && pwdata[1:0] != 2'b00
    |=> req.radio) else $error("radio write gave no request");
  a_t4_set: assert property (evt.timer_four |=> req.timer_four)
    else $error("timer four event lost");
  a_t1_clear: assert property (ack.timer_one && !evt.timer_one
    && !wr |=> !req.timer_one) else $error("timer one not cleared");
  a_wdog_hold: assert property (!evt.watchdog && !wr
    |=> $stable(req.watchdog)) else $error("watchdog flag moved");
  a_port2_set: assert property (evt.port_two |=> req.port_two)
    else $error("port two event lost");
endmodule // irq_flag_regs_properties
bind irq_flag_regs irq_flag_regs_properties i_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .evt, .ack, .req);

// File: verif/irq_src_model.sv
// peripheral event sources and core vector acknowledge
`timescale 1ns/1ns
module irq_src_model (
  input wire logic pclk,
  output irq_flag_pkg::irq_evt_s evt,
  output irq_flag_pkg::vec_ack_s ack
);
  initial begin
    evt = '0;
    ack = '0;
  end
  // pulses last exactly one cycle, as real sources do
  task automatic fire(input irq_flag_pkg::irq_evt_s e,
    input irq_flag_pkg::vec_ack_s a);
    @(posedge pclk);
    evt <= e;
    ack <= a;
    @(posedge pclk);
    evt <= '0;
    ack <= '0;
  endtask
endmodule // irq_src_model

// File: verif/irq_flag_regs_tb.sv
// register-level bench for the interrupt flag register block
`timescale 1ns/1ns
module irq_flag_regs_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  irq_flag_pkg::irq_evt_s evt;
  irq_flag_pkg::vec_ack_s ack;
  irq_flag_pkg::irq_req_s req;
  int error_cnt = 0;
  int n_tests = 0;
  always #5 pclk = ~pclk;
  irq_flag_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .evt, .ack, .req);
  irq_src_model i_src (.pclk, .evt, .ack);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  // idle cycle after each transfer keeps psel from two updates at one edge
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("[ERR] pready exp 1 got %b", pready);
      give_verdict();
    end
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, {24'h00_0000, d}, r, e);
  endtask
  task automatic rd(input string s, input logic [11:0] a,
    input logic [7:0] x);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
    chk(s, {24'h00_0000, x}, r);
    chk("mapped err", 32'h0000_0000, 32'(e));
  endtask
  initial begin
    logic [31:0] r;
    logic e;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("reg3 reset", irq_flag_pkg::ADDR_RADIO, 8'h00);
    rd("reg4 reset", irq_flag_pkg::ADDR_TIMER, 8'h00);
    rd("reg5 reset", irq_flag_pkg::ADDR_WDOG, 8'h00);
    $display("test reset done");
    wr(irq_flag_pkg::ADDR_RADIO, 8'hfc);
    chk("req unused", 32'h0000_0000, 32'(req));
    rd("reg3 unused", irq_flag_pkg::ADDR_RADIO, 8'hfc);
    wr(irq_flag_pkg::ADDR_RADIO, 8'h01);
    chk("req sw radio", 32'h0000_1000, 32'(req));
    wr(irq_flag_pkg::ADDR_RADIO, 8'h00);
    $display("test software done");
    i_src.fire('1, '0);
    rd("reg3 evt", irq_flag_pkg::ADDR_RADIO, 8'h03);
    rd("reg4 evt", irq_flag_pkg::ADDR_TIMER, 8'hbf);
    rd("reg5 evt", irq_flag_pkg::ADDR_WDOG, 8'h1f);
    chk("req evt", 32'h0000_1fff, 32'(req));
    i_src.fire('0, '1);
    rd("reg4 ack", irq_flag_pkg::ADDR_TIMER, 8'ha1);
    chk("req ack", 32'h0000_1c3f, 32'(req));
    $display("test events done");
    fork
      wr(irq_flag_pkg::ADDR_TIMER, 8'h00);
      i_src.fire(13'h0080, '0);
    join
    rd("reg4 race", irq_flag_pkg::ADDR_TIMER, 8'h04);
    wr(irq_flag_pkg::ADDR_WDOG, 8'h00);
    rd("reg5 clear", irq_flag_pkg::ADDR_WDOG, 8'h00);
    $display("test race done");
    xfer(1'b0, 12'h004, 32'h0000_0000, r, e);
    chk("unmapped err", 32'h0000_0001, 32'(e));
    // misaligned write must miss and leave the radio flags alone
    xfer(1'b1, irq_flag_pkg::ADDR_RADIO + 12'h001, 32'h0000_00fc, r, e);
    chk("misaligned err", 32'h0000_0001, 32'(e));
    rd("reg3 kept", irq_flag_pkg::ADDR_RADIO, 8'h03);
    $display("test unmapped done");
    give_verdict();
  end
endmodule // irq_flag_regs_tb
